// ===== hw/bmr_meas.sv
// Battery measurement result registers, filters, extremes and task ticker
`timescale 1ns/10ps
`default_nettype none
module bmr_meas #(
  parameter int          TASK_CYCLES = bmr_pkg::BMR_TASK_CYCLES,
  parameter logic [15:0] VGAIN       = 16'h8000,
  parameter logic [15:0] VOFFSET     = 16'h0000,
  parameter logic [4:0]  CUR_SHIFT   = 5'h4,
  parameter logic [4:0]  TEMP_SHIFT  = 5'h8,
  parameter logic [4:0]  VOLT_SHIFT  = 5'h6
) (
  // Clock, reset, enable
  input  wire logic              core_clk_in,
  input  wire logic              sys_rst_in,
  input  wire logic              ce_in,
  // Configuration
  input  wire bmr_pkg::bmr_cfg_t cfg_in,
  // Front end results (same clock)
  input  wire logic [15:0]       raw_cell_sample_in,
  input  wire logic [15:0]       analog_ratio_input_in,
  input  wire logic [15:0]       sense_pos_input_in,
  input  wire logic [15:0]       sense_neg_input_in,
  input  wire logic [15:0]       full_time_estimate_in,
  // Pin to be debounced
  input  wire logic              monitor_pin_in,
  // Register word port
  input  wire bmr_pkg::bmr_req_t req_in,
  output logic [15:0]            rdata_out,
  // Status
  output logic                   tick_out,
  output logic                   debounced_out,
  output logic [15:0]            delta_v_out,
  output logic                   delta_v_valid_out
);
  import bmr_pkg::*;

  localparam logic [22:0] TASK_LAST = 23'(TASK_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [22:0]        task_cnt_reg;
  logic               tick_reg;
  logic [15:0]        timer_reg;
  logic signed [15:0] thermal_reg;
  logic [15:0]        ratio_reg;
  logic [15:0]        cell_v_reg;
  logic [15:0]        vtap_reg [0:2];
  logic signed [15:0] current_reg;
  logic signed [31:0] avg_cur_reg;
  logic signed [31:0] avg_temp_reg;
  logic [31:0]        avg_volt_reg;
  logic               cur_seed_reg;
  logic               temp_seed_reg;
  logic               volt_seed_reg;
  logic [15:0]        ext_temp_reg;
  logic [15:0]        ext_volt_reg;
  logic [15:0]        ext_curr_reg;
  logic [15:0]        full_time_reg;
  logic [15:0]        rdata_reg;
  logic [2:0]         pin_sync_reg;
  logic               deb_reg;
  logic [3:0]         deb_cnt_reg;
  logic [15:0]        dv_base_reg;
  logic [15:0]        dv_cnt_reg;
  logic [15:0]        dv_reg;
  logic               dv_valid_reg;

  ////////////////////////////////////////////////////////////////////////////
  // IIR step; shifting the error keeps the 32-bit state free of drift
  function automatic logic [31:0] iir_step(input logic [31:0] acc,
                                           input logic [15:0] s,
                                           input logic        uns,
                                           input logic [4:0]  sh);
    logic signed [32:0] d;
    d = $signed({uns ? 1'b0 : s[15], s, 16'h0000})
      - $signed({uns ? 1'b0 : acc[31], acc});
    iir_step = acc + 32'(d >>> sh);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Schedule decode
  wire therm_due = tick_reg && (timer_reg[2:0] == BMR_THERM_PHASE);
  wire ratio_upd = therm_due && cfg_in.therm_en;
  wire temp_auto = ratio_upd && !cfg_in.ext_temp_sel;
  wire temp_wr   = req_in.wr && (req_in.addr == BMR_OFS_THERMAL)
                   && cfg_in.ext_temp_sel;
  wire temp_upd  = temp_auto || temp_wr;

  // Temperature from ratio: ratio * gain / 0x4000 + offset * 2
  wire signed [33:0] t_prod = $signed({2'b00, analog_ratio_input_in})
                            * $signed(cfg_in.thermal_gain_cfg);
  wire signed [15:0] t_calc = 16'(t_prod >>> BMR_THERM_GAIN_SHIFT)
                            + 16'(cfg_in.thermal_offset_cfg << 1);
  wire signed [15:0] temp_new = temp_wr ? $signed(req_in.wdata) : t_calc;

  // Cell voltage trim and four-tap FIR
  wire [31:0] v_prod = raw_cell_sample_in * VGAIN;
  wire [15:0] v_trim = 16'(v_prod >> BMR_VGAIN_SHIFT) + VOFFSET;
  wire [17:0] v_sum  = {2'b00, v_trim} + {2'b00, vtap_reg[0]}
                     + {2'b00, vtap_reg[1]} + {2'b00, vtap_reg[2]};
  wire [15:0] v_new  = v_sum[17:2];

  // Sense difference with saturation
  wire signed [16:0] c_diff = $signed({sense_pos_input_in[15],
                                       sense_pos_input_in})
                            - $signed({sense_neg_input_in[15],
                                       sense_neg_input_in});
  wire c_pos_sat = !c_diff[16] && c_diff[15];
  wire c_neg_sat = c_diff[16] && !c_diff[15];
  wire [15:0] c_new = c_pos_sat ? BMR_CUR_POS_SAT :
                      c_neg_sat ? BMR_CUR_NEG_SAT : c_diff[15:0];

  // Extremes candidates
  wire signed [7:0] t_byte = temp_new[15:8];
  wire [7:0] v_byte  = v_new[15:8];
  wire [15:0] c_mag  = c_new[15] ? 16'(-$signed(c_new)) : c_new;
  wire [7:0] c_byte  = c_mag[15:8];
  wire [15:0] ext_t_next = {
    (t_byte > $signed(ext_temp_reg[15:8])) ? t_byte : ext_temp_reg[15:8],
    (t_byte < $signed(ext_temp_reg[7:0]))  ? t_byte : ext_temp_reg[7:0]};
  wire [15:0] ext_v_next = {
    (v_byte > ext_volt_reg[15:8]) ? v_byte : ext_volt_reg[15:8],
    (v_byte < ext_volt_reg[7:0])  ? v_byte : ext_volt_reg[7:0]};
  wire c_chg = !c_new[15] && (c_byte > ext_curr_reg[15:8]);
  wire c_dis = c_new[15] && (c_byte > ext_curr_reg[7:0]);
  wire [15:0] ext_c_next = {c_chg ? c_byte : ext_curr_reg[15:8],
                            c_dis ? c_byte : ext_curr_reg[7:0]};

  // Debounce and voltage change decode
  wire        pin_stable = (pin_sync_reg[2] == pin_sync_reg[1]);
  wire        pin_diff   = pin_stable && (pin_sync_reg[1] != deb_reg);
  wire        dv_end     = (dv_cnt_reg + 16'h0001)
                           >= cfg_in.delta_v_tick_threshold;

  // Read decode
  wire [15:0] rd_mux =
    (req_in.addr == BMR_OFS_THERMAL)     ? thermal_reg :
    (req_in.addr == BMR_OFS_CELL_V)      ? cell_v_reg :
    (req_in.addr == BMR_OFS_CURRENT)     ? current_reg :
    (req_in.addr == BMR_OFS_AVG_CURRENT) ? avg_cur_reg[31:16] :
    (req_in.addr == BMR_OFS_AVG_THERMAL) ? avg_temp_reg[31:16] :
    (req_in.addr == BMR_OFS_AVG_CELL_V)  ? avg_volt_reg[31:16] :
    (req_in.addr == BMR_OFS_EXT_THERMAL) ? ext_temp_reg :
    (req_in.addr == BMR_OFS_EXT_VOLT)    ? ext_volt_reg :
    (req_in.addr == BMR_OFS_EXT_CURR)    ? ext_curr_reg :
    (req_in.addr == BMR_OFS_RATIO)       ? ratio_reg :
    (req_in.addr == BMR_OFS_FULL_TIME)   ? full_time_reg :
    (req_in.addr == BMR_OFS_TICK)        ? timer_reg : BMR_RST_WORD;

  ////////////////////////////////////////////////////////////////////////////
  // Task ticker and tick counter
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      task_cnt_reg <= '0;
      tick_reg     <= 1'b0;
      timer_reg    <= BMR_RST_WORD;
    end else if (ce_in) begin
      tick_reg     <= (task_cnt_reg == TASK_LAST);
      task_cnt_reg <= (task_cnt_reg == TASK_LAST) ? '0 : task_cnt_reg + 23'h1;
      if (tick_reg) begin
        timer_reg <= timer_reg + 16'h0001;
      end
    end
  end

  // Temperature and ratio input
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      thermal_reg <= BMR_RST_WORD;
      ratio_reg   <= BMR_RST_WORD;
    end else if (ce_in) begin
      if (ratio_upd) begin
        ratio_reg <= analog_ratio_input_in;
      end
      if (temp_upd) begin
        thermal_reg <= temp_new;
      end
    end
  end

  // Cell voltage FIR taps, sampled per task tick
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cell_v_reg  <= BMR_RST_WORD;
      vtap_reg[0] <= BMR_RST_WORD;
      vtap_reg[1] <= BMR_RST_WORD;
      vtap_reg[2] <= BMR_RST_WORD;
    end else if (ce_in && tick_reg) begin
      cell_v_reg  <= v_new;
      vtap_reg[0] <= v_trim;
      vtap_reg[1] <= vtap_reg[0];
      vtap_reg[2] <= vtap_reg[1];
    end
  end

  // Current sample per task tick
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      current_reg <= BMR_RST_WORD;
    end else if (ce_in && tick_reg) begin
      current_reg <= c_new;
    end
  end

  // IIR averages; the first sample after reset seeds each one
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      avg_cur_reg   <= '0;
      avg_temp_reg  <= '0;
      avg_volt_reg  <= '0;
      cur_seed_reg  <= 1'b0;
      temp_seed_reg <= 1'b0;
      volt_seed_reg <= 1'b0;
    end else if (ce_in) begin
      if (tick_reg) begin
        cur_seed_reg  <= 1'b1;
        volt_seed_reg <= 1'b1;
        avg_cur_reg   <= cur_seed_reg ?
          iir_step(avg_cur_reg, c_new, 1'b0, CUR_SHIFT) :
          {c_new, 16'h0000};
        avg_volt_reg  <= volt_seed_reg ?
          iir_step(avg_volt_reg, v_new, 1'b1, VOLT_SHIFT) :
          {v_new, 16'h0000};
      end
      if (temp_upd) begin
        temp_seed_reg <= 1'b1;
        avg_temp_reg  <= temp_seed_reg ?
          iir_step(avg_temp_reg, temp_new, 1'b0, TEMP_SHIFT) :
          {temp_new, 16'h0000};
      end
    end
  end

  // Extremes tracking
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ext_temp_reg <= BMR_RST_EXT_THERMAL;
      ext_volt_reg <= BMR_RST_EXT_VOLT;
      ext_curr_reg <= BMR_RST_EXT_CURR;
    end else if (ce_in) begin
      if (temp_upd) begin
        ext_temp_reg <= ext_t_next;
      end
      if (tick_reg) begin
        ext_volt_reg <= ext_v_next;
        ext_curr_reg <= ext_c_next;
      end
    end
  end

  // Pin synchroniser and eight-tick debounce
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pin_sync_reg <= 3'h0;
      deb_reg      <= 1'b0;
      deb_cnt_reg  <= 4'h0;
    end else if (ce_in) begin
      pin_sync_reg <= {pin_sync_reg[1:0], monitor_pin_in};
      if (!pin_diff) begin
        deb_cnt_reg <= 4'h0;
      end else if (tick_reg) begin
        if (deb_cnt_reg + 4'h1 >= BMR_DEBOUNCE_TICKS) begin
          deb_reg     <= pin_sync_reg[1];
          deb_cnt_reg <= 4'h0;
        end else begin
          deb_cnt_reg <= deb_cnt_reg + 4'h1;
        end
      end
    end
  end

  // Voltage change interval
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      dv_base_reg  <= BMR_RST_WORD;
      dv_cnt_reg   <= BMR_RST_WORD;
      dv_reg       <= BMR_RST_WORD;
      dv_valid_reg <= 1'b0;
    end else if (ce_in) begin
      dv_valid_reg <= 1'b0;
      if (tick_reg) begin
        if (dv_end) begin
          dv_reg       <= v_new - dv_base_reg;
          dv_valid_reg <= 1'b1;
          dv_base_reg  <= v_new;
          dv_cnt_reg   <= BMR_RST_WORD;
        end else begin
          dv_cnt_reg <= dv_cnt_reg + 16'h0001;
        end
      end
    end
  end

  // Read data and full-time snapshot; reads answer one cycle later
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rdata_reg     <= BMR_RST_WORD;
      full_time_reg <= BMR_RST_WORD;
    end else if (ce_in) begin
      full_time_reg <= full_time_estimate_in;
      if (req_in.rd) begin
        rdata_reg <= rd_mux;
      end
    end
  end

  assign rdata_out         = rdata_reg;
  assign tick_out          = tick_reg;
  assign debounced_out     = deb_reg;
  assign delta_v_out       = dv_reg;
  assign delta_v_valid_out = dv_valid_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);

  sequence s_therm_tick;
    ce_in && tick_reg && timer_reg[2:0] == BMR_THERM_PHASE;
  endsequence

  a_timer_step: assert property (
    ce_in && tick_reg |=> timer_reg == $past(timer_reg) + 16'h0001)
    else $error("tick counter did not advance");
  a_ratio_every8: assert property (
    s_therm_tick ##0 cfg_in.therm_en |=> ratio_reg == $past(analog_ratio_input_in))
    else $error("ratio input not refreshed");
  a_ratio_hold: assert property (
    ce_in && !(tick_reg && timer_reg[2:0] == BMR_THERM_PHASE) |=> $stable(ratio_reg))
    else $error("ratio input changed off schedule");
  a_cur_pos_sat: assert property (
    ce_in && tick_reg && c_diff > 17'sd32767 |=> current_reg == BMR_CUR_POS_SAT)
    else $error("positive current not saturated");
  a_cur_neg_sat: assert property (
    ce_in && tick_reg && c_diff < -17'sd32768 |=> current_reg == BMR_CUR_NEG_SAT)
    else $error("negative current not saturated");
  a_ext_temp_wr: assert property (
    ce_in && temp_wr |=> thermal_reg == $past(req_in.wdata))
    else $error("host temperature write lost");
  a_ext_temp_hold: assert property (
    ce_in && cfg_in.ext_temp_sel && !temp_wr |=> $stable(thermal_reg))
    else $error("temperature changed in external mode");
  a_avg_cur_seed: assert property (
    ce_in && tick_reg && !cur_seed_reg |=> avg_cur_reg[31:16] == current_reg)
    else $error("current average not seeded");
  a_temp_max_byte: assert property (
    ce_in && temp_upd |=> $signed(ext_temp_reg[15:8]) >= $signed(thermal_reg[15:8]))
    else $error("temperature maximum below reading");
endmodule
`default_nettype wire

// ===== hw/bmr_pkg.sv
// Package: register map, timing constants and carrier types for bmr_meas
package bmr_pkg;

  // Register offsets on the serial word port
  localparam logic [7:0] BMR_OFS_THERMAL     = 8'h08;
  localparam logic [7:0] BMR_OFS_CELL_V      = 8'h09;
  localparam logic [7:0] BMR_OFS_CURRENT     = 8'h0a;
  localparam logic [7:0] BMR_OFS_AVG_CURRENT = 8'h0b;
  localparam logic [7:0] BMR_OFS_AVG_THERMAL = 8'h16;
  localparam logic [7:0] BMR_OFS_AVG_CELL_V  = 8'h19;
  localparam logic [7:0] BMR_OFS_EXT_THERMAL = 8'h1a;
  localparam logic [7:0] BMR_OFS_EXT_VOLT    = 8'h1b;
  localparam logic [7:0] BMR_OFS_EXT_CURR    = 8'h1c;
  localparam logic [7:0] BMR_OFS_RATIO       = 8'h27;
  localparam logic [7:0] BMR_OFS_FULL_TIME   = 8'h33;
  localparam logic [7:0] BMR_OFS_TICK        = 8'h3e;

  // Timing: task interval in microseconds, clock in kHz
  localparam int          BMR_CLK_KHZ        = 40000;
  localparam int          BMR_TASK_US        = 175800;
  // Divide the clock first: the plain product overflows a 32-bit int
  localparam int          BMR_TASK_CYCLES    = BMR_TASK_US * (BMR_CLK_KHZ / 1000);
  localparam logic [2:0]  BMR_THERM_PHASE    = 3'h7;
  localparam logic [3:0]  BMR_DEBOUNCE_TICKS = 4'h8;

  // Reset values of the extremes bytes and of the other registers
  localparam logic [15:0] BMR_RST_EXT_THERMAL = 16'h807f;
  localparam logic [15:0] BMR_RST_EXT_VOLT    = 16'h00ff;
  localparam logic [15:0] BMR_RST_EXT_CURR    = 16'h0000;
  localparam logic [15:0] BMR_RST_WORD        = 16'h0000;

  // Saturation codes of the current reading
  localparam logic [15:0] BMR_CUR_POS_SAT = 16'h7fff;
  localparam logic [15:0] BMR_CUR_NEG_SAT = 16'h8000;

  // Gain divisor shifts: thermistor translation and cell voltage trim
  localparam int BMR_THERM_GAIN_SHIFT = 14;
  localparam int BMR_VGAIN_SHIFT      = 15;

  // Configuration carrier
  typedef struct packed {
    logic        ext_temp_sel;
    logic        therm_en;
    logic [15:0] thermal_gain_cfg;
    logic [15:0] thermal_offset_cfg;
    logic [15:0] delta_v_tick_threshold;
  } bmr_cfg_t;

  // Register port request carrier
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } bmr_req_t;

endpackage

// ===== bench/bmr_host_model.sv
// Host side model: word reads and writes on the register port
`timescale 1ns/10ps
`default_nettype none
module bmr_host_model (
  // Clock and read data
  input  wire logic              core_clk_in,
  input  wire logic [15:0]       rdata_in,
  // Request to the device
  output var  bmr_pkg::bmr_req_t req_out
);
  import bmr_pkg::*;
  initial req_out = '0;

  ////////////////////////////////////////////////////////////////////////////
  // Read: strobe taken at one edge, data settled just after it
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    req_out = {1'b1, 1'b0, a, 16'h0000}; // Read, write, address, data
    @(posedge core_clk_in);
    #2;
    d = rdata_in;
    req_out = '0;
    @(posedge core_clk_in); // Gap so the strobe is never re-raised at once
    #2;
  endtask

  // Write: one word strobed at one edge, then a gap cycle
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    req_out = {1'b0, 1'b1, a, d};
    @(posedge core_clk_in);
    #2;
    req_out = '0;
    @(posedge core_clk_in);
    #2;
  endtask
endmodule
`default_nettype wire

// ===== bench/test_bmr_meas.sv
// Self-checking bench for the measurement result registers
`timescale 1ns/10ps
`default_nettype none
module test_bmr_meas;
  import bmr_pkg::*;
  logic        core_clk, sys_rst;
  bmr_cfg_t    cfg;
  bmr_req_t    req;
  logic [15:0] raw, ratio, spos, sneg, ftime, rdata, dv, d;
  logic        mon, tick, deb, dvv, ce;
  int          bad_count, num_checks, n;

  ////////////////////////////////////////////////////////////////////////////
  // Short task period keeps the run brief
  bmr_meas #(.TASK_CYCLES(16)) uut (
    .core_clk_in          (core_clk),
    .sys_rst_in           (sys_rst),
    .ce_in                (ce),
    .cfg_in               (cfg),
    .raw_cell_sample_in   (raw),
    .analog_ratio_input_in(ratio),
    .sense_pos_input_in   (spos),
    .sense_neg_input_in   (sneg),
    .full_time_estimate_in(ftime),
    .monitor_pin_in       (mon),
    .req_in               (req),
    .rdata_out            (rdata),
    .tick_out             (tick),
    .debounced_out        (deb),
    .delta_v_out          (dv),
    .delta_v_valid_out    (dvv)
  );

  bmr_host_model host (
    .core_clk_in(core_clk),
    .rdata_in   (rdata),
    .req_out    (req)
  );

  // 40 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    if (bad_count == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, g);
    num_checks++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] r;
    host.rd(a, r);
    chk($sformatf("reg %h", a), e, r);
  endtask

  // Cycle after a bounded wait for each tick, so updates have landed
  task automatic wait_tick(input int cnt);
    int k;
    for (int i = 0; i < cnt; i++) begin
      k = 0;
      @(posedge core_clk);
      #2;
      while (tick !== 1'b1) begin
        k++;
        if (k > 40) begin
          bad_count++;
          end_of_test();
        end
        @(posedge core_clk);
        #2;
      end
    end
    @(posedge core_clk);
    #2;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    bad_count = 0;
    num_checks = 0;
    sys_rst = 1'b1;
    ce = 1'b1;
    // Fields: external select, enable, gain, offset, change threshold
    cfg = {1'b0, 1'b1, 16'h4000, 16'h0010, 16'h0004};
    raw = 16'h0a00;
    ratio = 16'h1900;
    spos = 16'h0300;
    sneg = 16'h0100;
    ftime = 16'h1234;
    mon = 1'b0;
    repeat (16) @(posedge core_clk);
    #2;
    sys_rst = 1'b0;
    // Startup values before the first task tick
    rchk(BMR_OFS_TICK, 16'h0000);
    rchk(BMR_OFS_EXT_THERMAL, 16'h807f);
    rchk(BMR_OFS_EXT_VOLT, 16'h00ff);
    rchk(BMR_OFS_EXT_CURR, 16'h0000);
    // Tick spacing and counter steps
    wait_tick(1);
    // First tick: FIR holds one sample of four, average seeded from it
    rchk(BMR_OFS_CELL_V, 16'h0280);
    rchk(BMR_OFS_AVG_CELL_V, 16'h0280);
    n = 5; // One edge of wait and four of reads since the tick
    while (tick !== 1'b1 && n < 40) begin
      @(posedge core_clk);
      #2;
      n++;
    end
    chk("tick gap", 16'd16, n[15:0]);
    wait_tick(1);
    rchk(BMR_OFS_CURRENT, 16'h0200);
    rchk(BMR_OFS_AVG_CURRENT, 16'h0200);
    host.rd(BMR_OFS_TICK, d);
    wait_tick(3);
    rchk(BMR_OFS_TICK, d + 16'h0003);
    // Cell voltage after the averaging window fills
    wait_tick(4);
    rchk(BMR_OFS_CELL_V, 16'h0a00);
    host.rd(BMR_OFS_EXT_VOLT, d);
    chk("volt max", 16'h000a, {8'h00, d[15:8]});
    // Align one tick after a thermistor update
    n = 0;
    do begin
      wait_tick(1);
      host.rd(BMR_OFS_TICK, d);
      n++;
    end while (d[2:0] != 3'h1 && n < 9);
    if (d[2:0] != 3'h1) begin
      chk("tick align", 16'h0001, {13'h0000, d[2:0]});
      end_of_test();
    end
    rchk(BMR_OFS_RATIO, 16'h1900);
    rchk(BMR_OFS_THERMAL, 16'h1920);
    host.rd(BMR_OFS_EXT_THERMAL, d);
    chk("temp max", 16'h0019, {8'h00, d[15:8]});
    rchk(BMR_OFS_AVG_THERMAL, 16'h1920);
    ratio = 16'h1a00;
    wait_tick(6);
    rchk(BMR_OFS_THERMAL, 16'h1920);
    rchk(BMR_OFS_RATIO, 16'h1900);
    wait_tick(1);
    rchk(BMR_OFS_THERMAL, 16'h1a20);
    rchk(BMR_OFS_RATIO, 16'h1a00);
    // One step of the average toward the new reading
    rchk(BMR_OFS_AVG_THERMAL, 16'h1921);
    // Measurement disabled: ratio must hold
    cfg.therm_en = 1'b0;
    ratio = 16'h2000;
    wait_tick(8);
    rchk(BMR_OFS_RATIO, 16'h1a00);
    // Host-supplied temperature, refused writes, other reads
    cfg.ext_temp_sel = 1'b1;
    host.wr(BMR_OFS_THERMAL, 16'h0800);
    rchk(BMR_OFS_THERMAL, 16'h0800);
    cfg.ext_temp_sel = 1'b0;
    host.wr(BMR_OFS_THERMAL, 16'h0700);
    rchk(BMR_OFS_THERMAL, 16'h0800);
    host.wr(BMR_OFS_CELL_V, 16'h1111);
    rchk(BMR_OFS_CELL_V, 16'h0a00);
    rchk(8'h00, 16'h0000);
    rchk(BMR_OFS_FULL_TIME, 16'h1234);
    // Current peaks, then saturation both ways
    spos = 16'h0100;
    sneg = 16'h0600;
    wait_tick(1);
    rchk(BMR_OFS_CURRENT, 16'hfb00);
    rchk(BMR_OFS_EXT_CURR, 16'h0205);
    spos = 16'h7000;
    sneg = 16'h9000;
    wait_tick(1);
    rchk(BMR_OFS_CURRENT, BMR_CUR_POS_SAT);
    spos = 16'h9000;
    sneg = 16'h7000;
    wait_tick(1);
    rchk(BMR_OFS_CURRENT, BMR_CUR_NEG_SAT);
    // Debounce needs eight ticks of a stable pin
    mon = 1'b1;
    wait_tick(7);
    chk("debounce early", 16'h0000, {15'h0, deb});
    wait_tick(1);
    @(posedge core_clk);
    #2;
    chk("debounce late", 16'h0001, {15'h0, deb});
    // Voltage change interval equals the threshold in ticks
    n = 0;
    while (dvv !== 1'b1 && n < 200) begin
      @(posedge core_clk);
      #2;
      n++;
    end
    if (dvv !== 1'b1) begin
      chk("dv first pulse", 16'h0001, 16'h0000);
      end_of_test();
    end
    n = 0;
    for (int c = 0; c < 200; c++) begin
      @(posedge core_clk);
      #2;
      if (tick === 1'b1)
        n++;
      if (dvv === 1'b1)
        break;
    end
    if (dvv !== 1'b1) begin
      chk("dv next pulse", 16'h0001, 16'h0000);
      end_of_test();
    end
    chk("dv ticks", 16'd4, n[15:0]);
    chk("dv value", 16'h0000, dv);
    // Clock enable low freezes the ticker across two task periods
    host.rd(BMR_OFS_TICK, d);
    ce = 1'b0;
    repeat (40) @(posedge core_clk);
    #2;
    ce = 1'b1;
    rchk(BMR_OFS_TICK, d);
    end_of_test();
  end
endmodule
`default_nettype wire
